/* File: rtl/sxo_pkg.sv */
// Summary of operation
// - Opcode 10011rrr subtracts carry and working register rrr from the accumulator in one cycle.
// - Opcode 10010101 with a data address byte subtracts carry and that byte from the accumulator in one cycle.
// - Opcode 11000101 with a data address byte swaps the accumulator and that byte in one cycle.
// - Opcode 1100011r swaps the accumulator with the byte addressed through R0 or R1.
// - Opcode 11001rrr swaps the accumulator with working register rrr.
// - Opcode 11000100 swaps the upper and lower nibbles of the accumulator.
// - Opcode 1101011r swaps only the low nibbles of the accumulator and the indirectly addressed byte in one cycle.
// - Every indirect form takes its address from R0 or R1 as picked by opcode bit 0.
// - Opcode 0110011r XORs the indirectly addressed byte into the accumulator and changes only parity.
// - Opcode 01100100 XORs an immediate byte into the accumulator.
// - Opcode 01101rrr XORs working register rrr into the accumulator.
// - Opcode 01100101 with a data address byte XORs that byte into the accumulator in one cycle.
// - Opcode 01100011 with address and immediate bytes writes their XOR back to memory over two cycles.
// - Opcode 01100010 with a data address byte writes the accumulator XOR that byte back to memory in one cycle.
package sxo_pkg;
   localparam logic [7:0] SXO_ACC_RST = 8'h00;
   localparam logic [7:0] SXO_PSW_RST = 8'h00;
   // Flag positions in the program status word
   localparam int SXO_CY_BIT = 7;
   localparam int SXO_HC_BIT = 6;
   localparam int SXO_OV_BIT = 2;
   localparam int SXO_P_BIT = 0;
   // Opcodes and opcode patterns
   localparam logic [7:0] SXO_OP_SUBTRACT_WITH_BORROW_OP_IMM = 8'h94;
   localparam logic [7:0] SXO_OP_SUBTRACT_WITH_BORROW_OP_DIR = 8'h95;
   localparam logic [6:0] SXO_OP_SUBTRACT_WITH_BORROW_OP_IND = 7'h4B;
   localparam logic [4:0] SXO_OP_SUBTRACT_WITH_BORROW_OP_REG = 5'h13;
   localparam logic [7:0] SXO_OP_SWAP = 8'hC4;
   localparam logic [7:0] SXO_OP_XCH_DIR = 8'hC5;
   localparam logic [6:0] SXO_OP_XCH_IND = 7'h63;
   localparam logic [4:0] SXO_OP_XCH_REG = 5'h19;
   localparam logic [6:0] SXO_OP_LOW_NIBBLE_EXCHANGE_OP_IND = 7'h6B;
   localparam logic [7:0] SXO_OP_XRL_MA = 8'h62;
   localparam logic [7:0] SXO_OP_XRL_MI = 8'h63;
   localparam logic [7:0] SXO_OP_XRL_IMM = 8'h64;
   localparam logic [7:0] SXO_OP_XRL_DIR = 8'h65;
   localparam logic [6:0] SXO_OP_XRL_IND = 7'h33;
   localparam logic [4:0] SXO_OP_XRL_REG = 5'h0D;
   localparam int SXO_XRL_MI_CYCLES = 2;

   typedef enum logic [0:0] {
      SXO_ST_IDLE = 1'b0,
      SXO_ST_WAIT = 1'b1
   } sxo_state_t;

   // One instruction as handed in by fetch
   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic [7:0] byte2;
      logic [7:0] byte3;
   } sxo_instr_t;

   // Data memory port; reads are combinational
   typedef struct packed {
      logic [7:0] addr;
      logic wr_en;
      logic [7:0] wr_data;
   } sxo_mem_req_t;

   typedef struct packed {
      sxo_state_t state;
      logic [7:0] acc;
      logic [7:0] program_status_word;
      logic busy;
      logic done;
      logic illegal;
   } sxo_core_t;
endpackage

/* File: rtl/sxo_sub_borrow.sv */
`timescale 1ns/10ps
`default_nettype none
// Accumulator minus carry minus operand, with flags
module sxo_sub_borrow
   import sxo_pkg::*;
(
   input wire logic [7:0] acc_i,
   input wire logic [7:0] opnd_i,
   input wire logic cy_i,
   output logic [7:0] diff_o,
   output logic cy_o,
   output logic hc_o,
   output logic ov_o
);
   logic [4:0] low;
   logic [8:0] full;

   // Separate low nibble sum gives the bit 3 borrow
   always_comb begin
      low = {1'b0, acc_i[3:0]} - {1'b0, opnd_i[3:0]} - {4'h0, cy_i};
      full = {1'b0, acc_i} - {1'b0, opnd_i} - {8'h00, cy_i};
      diff_o = full[7:0];
      cy_o = full[8];
      hc_o = low[4];
      ov_o = (acc_i[7] ^ opnd_i[7]) & (acc_i[7] ^ full[7]);
   end
endmodule
`default_nettype wire

/* File: rtl/sxo_exec.sv */
`timescale 1ns/10ps
`default_nettype none
// Executes subtract, exchange and XOR group against acc, PROGRAM_STATUS_WORD, bank and memory
module sxo_exec
   import sxo_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire sxo_instr_t instr_i,
   input wire logic [7:0] bank_reg_i[8],
   input wire logic [7:0] mem_rd_data_i,
   output sxo_mem_req_t mem_req_o,
   output logic [2:0] reg_sel_o,
   output logic reg_wr_en_o,
   output logic [7:0] reg_wr_data_o,
   output logic [7:0] acc_o,
   output logic [7:0] psw_o,
   output logic ready_o,
   output logic done_o,
   output logic illegal_o
);
   sxo_core_t cur, next_cur;
   logic [7:0] opnd, sub_res;
   logic sub_cy, sub_hc, sub_ov, take;
   logic [7:0] op;
   logic [7:0] ind_addr;

   // Datapath overview:
   // Decode strobes pick one form per instruction
   // One shared operand mux feeds both the subtractor and the XOR
   // One state struct holds acc, psw and the two-cycle sequencer
   // Direct, indirect and register exchanges send the old accumulator out through memory or register port

   // Decode strobes, one per instruction form
   logic is_subtract_with_borrow_op_reg, is_subtract_with_borrow_op_dir, is_subtract_with_borrow_op_imm, is_subtract_with_borrow_op_ind;
   logic is_swap, is_xch_dir, is_xch_ind, is_xch_reg, is_low_nibble_exchange_op_ind;
   logic is_xrl_ma, is_xrl_mi, is_xrl_imm, is_xrl_dir, is_xrl_ind, is_xrl_reg;
   // Group strobes shared by operand select and execute
   logic is_subtract_with_borrow_op, is_xrl_acc, is_ind, is_reg, is_imm;

   assign op = instr_i.opcode;
   assign take = instr_i.valid && cur.state == SXO_ST_IDLE;
   assign ind_addr = bank_reg_i[{2'b00, op[0]}];
   assign reg_sel_o = op[2:0];

   // Subtract-with-borrow forms
   assign is_subtract_with_borrow_op_reg = op[7:3] == SXO_OP_SUBTRACT_WITH_BORROW_OP_REG;
   assign is_subtract_with_borrow_op_dir = op == SXO_OP_SUBTRACT_WITH_BORROW_OP_DIR;
   assign is_subtract_with_borrow_op_imm = op == SXO_OP_SUBTRACT_WITH_BORROW_OP_IMM;
   assign is_subtract_with_borrow_op_ind = op[7:1] == SXO_OP_SUBTRACT_WITH_BORROW_OP_IND;

   // Exchange forms; the nibble swap touches only the accumulator
   assign is_swap = op == SXO_OP_SWAP;
   assign is_xch_dir = op == SXO_OP_XCH_DIR;
   assign is_xch_ind = op[7:1] == SXO_OP_XCH_IND;
   assign is_xch_reg = op[7:3] == SXO_OP_XCH_REG;
   assign is_low_nibble_exchange_op_ind = op[7:1] == SXO_OP_LOW_NIBBLE_EXCHANGE_OP_IND;

   // Exclusive-OR forms; the memory-destination pair leaves acc alone
   assign is_xrl_ma = op == SXO_OP_XRL_MA;
   assign is_xrl_mi = op == SXO_OP_XRL_MI;
   assign is_xrl_imm = op == SXO_OP_XRL_IMM;
   assign is_xrl_dir = op == SXO_OP_XRL_DIR;
   assign is_xrl_ind = op[7:1] == SXO_OP_XRL_IND;
   assign is_xrl_reg = op[7:3] == SXO_OP_XRL_REG;

   // Groups; form decodes never overlap, so at most one strobe is high
   assign is_subtract_with_borrow_op = is_subtract_with_borrow_op_reg || is_subtract_with_borrow_op_dir || is_subtract_with_borrow_op_imm || is_subtract_with_borrow_op_ind;
   assign is_xrl_acc = is_xrl_ind || is_xrl_imm || is_xrl_reg || is_xrl_dir;
   assign is_ind = is_subtract_with_borrow_op_ind || is_xch_ind || is_low_nibble_exchange_op_ind || is_xrl_ind;
   assign is_reg = is_subtract_with_borrow_op_reg || is_xch_reg || is_xrl_reg;
   assign is_imm = is_subtract_with_borrow_op_imm || is_xrl_imm;

   // Operand select: register, indirect, direct or immediate
   always_comb begin
      opnd = mem_rd_data_i;
      if (is_reg) begin
         opnd = bank_reg_i[op[2:0]];
      end else if (is_imm) begin
         opnd = instr_i.byte2;
      end
   end

   sxo_sub_borrow u_sub (
      .acc_i(cur.acc),
      .opnd_i(opnd),
      .cy_i(cur.program_status_word[SXO_CY_BIT]),
      .diff_o(sub_res),
      .cy_o(sub_cy),
      .hc_o(sub_hc),
      .ov_o(sub_ov)
   );

   // Decode and execute; memory write path held for the second cycle
   always_comb begin
      next_cur = cur;
      next_cur.done = 1'b0;
      next_cur.illegal = 1'b0;
      mem_req_o.addr = instr_i.byte2;
      mem_req_o.wr_en = 1'b0;
      mem_req_o.wr_data = 8'h00;
      reg_wr_en_o = 1'b0;
      reg_wr_data_o = cur.acc;
      // Indirect forms address memory through R0 or R1
      if (is_ind) begin
         mem_req_o.addr = ind_addr;
      end
      case (cur.state)
         SXO_ST_IDLE: begin
            if (take) begin
               next_cur.done = 1'b1;
               if (is_subtract_with_borrow_op) begin
                  // Flags from the shared subtractor
                  next_cur.acc = sub_res;
                  next_cur.program_status_word[SXO_CY_BIT] = sub_cy;
                  next_cur.program_status_word[SXO_HC_BIT] = sub_hc;
                  next_cur.program_status_word[SXO_OV_BIT] = sub_ov;
               end else if (is_xch_dir || is_xch_ind) begin
                  // Old accumulator goes out to memory
                  next_cur.acc = opnd;
                  mem_req_o.wr_en = 1'b1;
                  mem_req_o.wr_data = cur.acc;
               end else if (is_xch_reg) begin
                  // Old accumulator goes out to the bank
                  next_cur.acc = opnd;
                  reg_wr_en_o = 1'b1;
                  reg_wr_data_o = cur.acc;
               end else if (is_swap) begin
                  // Nibble swap, no memory traffic
                  next_cur.acc = {cur.acc[3:0], cur.acc[7:4]};
               end else if (is_low_nibble_exchange_op_ind) begin
                  // Upper nibbles stay where they are
                  next_cur.acc = {cur.acc[7:4], opnd[3:0]};
                  mem_req_o.wr_en = 1'b1;
                  mem_req_o.wr_data = {opnd[7:4], cur.acc[3:0]};
               end else if (is_xrl_acc) begin
                  // Accumulator-destination XOR
                  next_cur.acc = cur.acc ^ opnd;
               end else if (is_xrl_ma) begin
                  // Memory-destination XOR with the accumulator
                  mem_req_o.wr_en = 1'b1;
                  mem_req_o.wr_data = opnd ^ cur.acc;
               end else if (is_xrl_mi) begin
                  // Read and write both happen in the second cycle: the instruction must stay put
                  next_cur.state = SXO_ST_WAIT;
                  next_cur.busy = 1'b1;
                  next_cur.done = 1'b0;
               end else begin
                  // Unknown opcode: flag it, change nothing
                  next_cur.done = 1'b0;
                  next_cur.illegal = 1'b1;
               end
            end
         end

         // Second cycle of the memory XOR immediate form
         SXO_ST_WAIT: begin
            mem_req_o.wr_en = 1'b1;
            mem_req_o.wr_data = opnd ^ instr_i.byte3;
            next_cur.state = SXO_ST_IDLE;
            next_cur.busy = 1'b0;
            next_cur.done = 1'b1;
         end

         // Unreachable code: fall back to idle
         default: begin
            next_cur.state = SXO_ST_IDLE;
         end
      endcase
      // Parity follows whatever the accumulator becomes
      next_cur.program_status_word[SXO_P_BIT] = ^next_cur.acc;
   end

   // State register with synchronous reset
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cur.state <= SXO_ST_IDLE;
         cur.acc <= SXO_ACC_RST;
         cur.program_status_word <= SXO_PSW_RST;
         cur.busy <= 1'b0;
         cur.done <= 1'b0;
         cur.illegal <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   // Port timing notes:
   // acc, psw, done and illegal are flip-flop outputs
   // Memory and register write strobes are combinational, one cycle each
   // Read data is used in the same cycle as its address
   // No bypass: a write and a dependent read in one cycle see the old byte
   // ready low only in the second cycle of the memory XOR immediate form
   // Fetch must hold instr_i unchanged while ready is low
   // A valid instruction while ready is low is treated as the held one
   // Unknown opcodes raise illegal and leave all state untouched
   // Parity recomputed every cycle, so it can never go stale
   // Carry, half-carry and overflow change only on the subtract forms
   // Other status bits are kept but never written here

   // Registered outputs straight from the state struct
   assign acc_o = cur.acc;
   assign psw_o = cur.program_status_word;
   assign ready_o = !cur.busy; // Fetch must hold instr_i while low
   assign done_o = cur.done;
   assign illegal_o = cur.illegal;
endmodule
`default_nettype wire

/* File: verification/sxo_exec_props.sv */
`timescale 1ns/10ps
`default_nettype none
// Port-level timing and datapath checks
module sxo_exec_props
   import sxo_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire sxo_instr_t instr_i,
   input wire logic [7:0] bank_reg_i[8],
   input wire logic [7:0] mem_rd_data_i,
   input wire sxo_mem_req_t mem_req_o,
   input wire logic [7:0] acc_o,
   input wire logic [7:0] psw_o,
   input wire logic ready_o,
   input wire logic done_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Accepted at this edge; ready low means the held second cycle
   wire logic tk = instr_i.valid && ready_o;
   wire logic [7:0] op = instr_i.opcode;
   sequence mi_wr_s;
      !ready_o && mem_req_o.wr_en && mem_req_o.wr_data == (mem_rd_data_i ^ instr_i.byte3);
   endsequence
   sequence mi_end_s;
      ready_o && done_o;
   endsequence
   parity_track_a: assert property (psw_o[SXO_P_BIT] == ^acc_o) else $error("parity stale");
   xrl_imm_a: assert property (tk && op == SXO_OP_XRL_IMM |=> done_o && acc_o == ($past(acc_o) ^
      $past(instr_i.byte2))) else $error("xor immediate wrong");
   xrl_mi_seq_a: assert property (tk && op == SXO_OP_XRL_MI |=> mi_wr_s ##1 mi_end_s)
      else $error("memory xor immediate wrong");
   xrl_ma_a: assert property (tk && op == SXO_OP_XRL_MA |-> mem_req_o.wr_en && mem_req_o.addr ==
      instr_i.byte2 && mem_req_o.wr_data == (acc_o ^ mem_rd_data_i)) else $error("memory xor acc wrong");
   xch_dir_a: assert property (tk && op == SXO_OP_XCH_DIR |-> mem_req_o.wr_en && mem_req_o.wr_data ==
      acc_o ##1 acc_o == $past(mem_rd_data_i)) else $error("direct exchange wrong");
   low_nibble_exchange_op_low_a: assert property (tk && op[7:1] == SXO_OP_LOW_NIBBLE_EXCHANGE_OP_IND |-> mem_req_o.wr_en &&
      mem_req_o.addr == bank_reg_i[{2'h0, op[0]}] && mem_req_o.wr_data == {mem_rd_data_i[7:4], acc_o[3:0]})
      else $error("low nibble exchange wrong");
   xrl_ind_a: assert property (tk && op[7:1] == SXO_OP_XRL_IND |=> psw_o[7:1] == $past(psw_o[7:1])
      && acc_o == ($past(acc_o) ^ $past(mem_rd_data_i))) else $error("indirect xor wrong");
   swap_nib_a: assert property (tk && op == SXO_OP_SWAP |=> acc_o == {$past(acc_o[3:0]),
      $past(acc_o[7:4])}) else $error("nibble swap wrong");
endmodule
`default_nettype wire

/* File: verification/subtract_exchange_xor_ops_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module subtract_exchange_xor_ops_tb import sxo_pkg::*;;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   sxo_instr_t ins = '0;
   logic [7:0] bank[8], mem[256], rd, acc = 8'h00, ps = 8'h00, cmd, rwd, acc_o, psw_o;
   sxo_mem_req_t req;
   logic [2:0] rsel;
   logic rwe, done, ill, rdy;
   logic [32:0] q[$], nt;
   logic [15:0] r = 16'h8B58;
   int failures = 0;
   int num_checks = 0;
   logic [7:0] ops[16] = '{8'h98, 8'h95, 8'hC5, 8'hC6, 8'hC8, 8'hC4, 8'hD6, 8'h66,
      8'h64, 8'h68, 8'h65, 8'h63, 8'h62, 8'h94, 8'hA5, 8'h96};
   always #5 clk_i = ~clk_i;
   assign rd = mem[req.addr];
   sxo_exec i_sxo_exec (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_i(ins), .bank_reg_i(bank),
      .mem_rd_data_i(rd), .mem_req_o(req), .reg_sel_o(rsel), .reg_wr_en_o(rwe), .reg_wr_data_o(rwd),
      .acc_o(acc_o), .psw_o(psw_o), .ready_o(rdy), .done_o(done), .illegal_o(ill));
   // Far side takes the block's writes at the edge
   always @(posedge clk_i) begin
      if (req.wr_en === 1'b1) mem[req.addr] <= req.wr_data;
      if (rwe === 1'b1) bank[rsel] <= rwd;
   end
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (!ok) begin
         failures++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Predict from own state, then present; the memory xor form is held a second cycle
   task automatic run(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
      logic [7:0] o, wa, wm, t;
      logic [8:0] d;
      logic [4:0] h;
      logic bad;
      bad = 1'b0;
      wa = (op[2:1] == 2'h3) ? bank[{2'h0, op[0]}] : b2;
      wm = mem[wa];
      o = op[3] ? bank[op[2:0]] : (op[0] || op[2:1] == 2'h3) ? wm : b2;
      t = acc;
      casez (op)
         8'b1001????: begin
            d = {1'b0, acc} - o - ps[7];
            h = {1'b0, acc[3:0]} - o[3:0] - ps[7];
            ps[2] = (acc[7] != o[7]) && (d[7] != acc[7]);
            ps[7] = d[8];
            ps[6] = h[4];
            acc = d[7:0];
         end
         8'hC4: acc = {acc[3:0], acc[7:4]};
         8'hC5, 8'hC6, 8'hC7, 8'b11001???: begin
            acc = o;
            if (!op[3]) wm = t;
         end
         8'hD6, 8'hD7: begin
            acc = {acc[7:4], wm[3:0]};
            wm = {wm[7:4], t[3:0]};
         end
         8'h64, 8'h65, 8'h66, 8'h67, 8'b01101???: acc = acc ^ o;
         8'h62: wm = wm ^ acc;
         8'h63: wm = wm ^ b3;
         default: bad = 1'b1;
      endcase
      ps[0] = ^acc;
      q.push_back({bad, wa, wm, ps, acc});
      ins = '{1'b1, op, b2, b3};
      @(posedge clk_i);
      if (op == 8'h63) @(posedge clk_i);
      #1;
      if (op[7:3] == 5'h19) chk(bank[op[2:0]] === t, "register exchange");
   endtask
   // Scoreboard: oldest note against each completion
   always @(posedge clk_i) begin
      #2;
      if (done === 1'b1 || ill === 1'b1) begin
         chk(q.size() > 0, "unexpected completion");
         if (q.size() > 0) begin
            nt = q.pop_front();
            chk(ill === nt[32], "refusal flag");
            chk(acc_o === nt[7:0], "accumulator");
            chk(psw_o === nt[15:8], "status flags");
            chk(mem[nt[31:24]] === nt[23:16], "memory byte");
         end
      end
   end
   initial begin
      for (int i = 0; i < 256; i++) begin
         r = nx(r);
         mem[i] = r[7:0];
         if (i < 8) bank[i] = r[15:8];
      end
      repeat (12) @(posedge clk_i);
      #1 sys_rst_i = 1'b0;
      // Back-to-back random stream over every form
      for (int n = 0; n < 400; n++) begin
         r = nx(r);
         cmd = ops[r[3:0]];
         if (cmd[3]) cmd[2:0] = r[6:4];
         else if (cmd[2:1] == 2'h3) cmd[0] = r[4];
         run(cmd, r[15:8], r[11:4]);
      end
      ins.valid = 1'b0;
      repeat (3) @(posedge clk_i);
      chk(q.size() == 0, "missing completions");
      $display("random stream finished");
      tally_and_finish;
   end
   initial begin
      #50000;
      failures++;
      tally_and_finish;
   end
endmodule
bind sxo_exec sxo_exec_props i_sxo_exec_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_i(instr_i),
   .bank_reg_i(bank_reg_i), .mem_rd_data_i(mem_rd_data_i), .mem_req_o(mem_req_o), .acc_o(acc_o),
   .psw_o(psw_o), .ready_o(ready_o), .done_o(done_o));
`default_nettype wire
